/* File: hw/cfl_pkg.sv */
// Constants, types and register index map of the CPU register file.
// Overview of operation
// - Each 32-bit data pair is also reachable as an upper and a lower 16-bit half, each at its own index.
// - The first two data pairs are also reachable as four 8-bit registers each, from lower byte to upper byte.
// - The four 32-bit address registers behave like data registers and supply the base for indirect and relative addressing.
// - The 32-bit static base register supplies the base added to an offset for static-base-relative addressing.
// - The 32-bit frame base register supplies the base added to an offset for frame-base-relative addressing.
// - The 32-bit program counter always holds the address of the next instruction to execute.
// - The 32-bit vector table base register holds the start address of the relocatable vector table.
// - Two full banks exist, each with the four data pairs, four address registers, static base and frame base.
// - A user and an interrupt stack pointer exist, and flag bit 7 chooses which one is the active stack pointer.
// - The carry flag captures the carry, borrow or shifted-out bit that the ALU reports for the current operation.
// - The zero flag becomes one when a result equals zero and zero for any other result.
// - The sign flag becomes one when a result is negative and zero otherwise.
package cfl_pkg;

  localparam int unsigned REG_W = 32;
  localparam int unsigned BANK_REGS = 10;

  // Whole-register indices; 0 to 9 live in the active bank.
  localparam logic [4:0] IDX_DATA_PAIR_ZERO = 5'h00;
  localparam logic [4:0] IDX_DATA_PAIR_ONE = 5'h01;
  localparam logic [4:0] IDX_DATA_PAIR_TWO = 5'h02;
  localparam logic [4:0] IDX_DATA_PAIR_THREE = 5'h03;
  localparam logic [4:0] IDX_ADDRESS_REG_ZERO = 5'h04;
  localparam logic [4:0] IDX_ADDRESS_REG_ONE = 5'h05;
  localparam logic [4:0] IDX_ADDRESS_REG_TWO = 5'h06;
  localparam logic [4:0] IDX_ADDRESS_REG_THREE = 5'h07;
  localparam logic [4:0] IDX_STATIC_BASE = 5'h08;
  localparam logic [4:0] IDX_FRAME_BASE = 5'h09;
  localparam logic [4:0] IDX_NEXT_INSTR_POINTER = 5'h0A;
  localparam logic [4:0] IDX_VECTOR_TABLE_BASE = 5'h0B;
  localparam logic [4:0] IDX_USER_STACK_POINTER = 5'h0C;
  localparam logic [4:0] IDX_IRQ_STACK_POINTER = 5'h0D;
  localparam logic [4:0] IDX_CPU_STATUS_FLAGS = 5'h0E;
  localparam logic [4:0] IDX_ACTIVE_STACK = 5'h0F;
  // Halves: base + 2*pair + upper. Bytes: base + 4*pair + byte number.
  localparam logic [4:0] IDX_HALF_BASE = 5'h10;
  localparam logic [4:0] IDX_BYTE_BASE = 5'h18;
  localparam logic [4:0] IDX_PAIR_ZERO_UPPER_HALF = 5'h11;
  localparam logic [4:0] IDX_PAIR_ONE_LOWER_HALF = 5'h12;
  localparam logic [4:0] IDX_PAIR_ZERO_BYTE0 = 5'h18;
  localparam logic [4:0] IDX_PAIR_ONE_BYTE0 = 5'h1C;
  localparam logic [4:0] IDX_PAIR_ONE_BYTE3 = 5'h1F;

  // Flag register layout.
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_DEBUG = 1;
  localparam int unsigned FLAG_ZERO = 2;
  localparam int unsigned FLAG_SIGN = 3;
  localparam int unsigned FLAG_BANK = 4;
  localparam int unsigned FLAG_STACK_SEL = 7;
  localparam logic [31:0] FLAG_WMASK = 32'h0000_009F;

  localparam logic [31:0] RST_REG = 32'h0000_0000;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;

  typedef enum logic [2:0] {
    BASE_ADR0 = 3'h0,
    BASE_ADR1 = 3'h1,
    BASE_ADR2 = 3'h2,
    BASE_ADR3 = 3'h3,
    BASE_STATIC = 3'h4,
    BASE_FRAME = 3'h5,
    BASE_VEC = 3'h6
  } cfl_base_t;

  typedef struct packed {
    logic we;
    logic [31:0] result;
    logic carry;
  } cfl_alu_upd_t;

  typedef struct packed {
    logic valid;
    cfl_base_t base;
    logic [31:0] offset;
  } cfl_ea_req_t;

  typedef struct packed {
    logic [1:0][BANK_REGS-1:0][31:0] bank;
    logic [31:0] pc;
    logic [31:0] vtb;
    logic [31:0] usr_sp;
    logic [31:0] irq_sp;
    logic [31:0] flags;
    logic [31:0] sp;
    logic [31:0] rdata;
    logic [31:0] ea;
    logic ea_valid;
  } cfl_state_t;

endpackage

/* File: hw/cfl_regfile.sv */
// CPU register file: banked general registers, pointers and flags.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module cfl_regfile
  import cfl_pkg::*;
#(
  parameter int unsigned PC_STEP_W = 4
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire cfl_alu_upd_t alu_upd,
  input wire logic [PC_STEP_W-1:0] pc_step,
  input wire cfl_ea_req_t ea_req,
  output logic [31:0] ea_addr,
  output logic ea_valid,
  output logic [31:0] sp_active,
  output logic [31:0] next_instr_pointer,
  output logic [31:0] cpu_status_flags
);

  generate
    if (PC_STEP_W < 1 || PC_STEP_W > 8) begin : g_bad_step
      $error("PC_STEP_W must lie between 1 and 8");
    end
  endgenerate

  localparam cfl_state_t RST_STATE = '{
    bank: '0,
    pc: RST_REG,
    vtb: RST_REG,
    usr_sp: RST_REG,
    irq_sp: RST_REG,
    flags: RST_FLAGS,
    sp: RST_REG,
    rdata: RST_REG,
    ea: RST_REG,
    ea_valid: 1'b0
  };

  cfl_state_t q;
  cfl_state_t d;
  logic [3:0] full_idx;
  logic [4:0] shift;
  logic [31:0] mask;
  logic [4:0] idx5;
  logic bk;
  logic [31:0] full;
  logic [31:0] merged;
  logic [31:0] base;

  cfl_subreg_map u_map (
    .addr(reg_addr),
    .full_idx(full_idx),
    .shift(shift),
    .mask(mask)
  );

  assign idx5 = {1'b0, full_idx};

  always_comb begin
    d = q;
    // The bank flag picks which copy of the ten banked registers is seen.
    bk = q.flags[FLAG_BANK];

    unique case (idx5)
      IDX_NEXT_INSTR_POINTER: full = q.pc;
      IDX_VECTOR_TABLE_BASE: full = q.vtb;
      IDX_USER_STACK_POINTER: full = q.usr_sp;
      IDX_IRQ_STACK_POINTER: full = q.irq_sp;
      IDX_CPU_STATUS_FLAGS: full = q.flags;
      IDX_ACTIVE_STACK: full = q.sp;
      default: full = q.bank[bk][full_idx];
    endcase

    // Only the addressed lanes take new data; the rest keep their value.
    merged = (full & ~mask) | ((reg_wdata << shift) & mask);

    // Read data stands only in the cycle after the read strobe.
    d.rdata = '0;
    if (reg_rd) begin
      d.rdata = (full & mask) >> shift;
    end

    // The counter advances by the decoded length unless software loads it.
    d.pc = q.pc + 32'(pc_step);

    if (reg_wr) begin
      unique case (idx5)
        IDX_NEXT_INSTR_POINTER: d.pc = merged;
        IDX_VECTOR_TABLE_BASE: d.vtb = merged;
        IDX_USER_STACK_POINTER: d.usr_sp = merged;
        IDX_IRQ_STACK_POINTER: d.irq_sp = merged;
        // The debug flag is stored as written; keeping it zero is up to
        // software. Unused flag bits stay zero so they always read zero.
        IDX_CPU_STATUS_FLAGS: d.flags = merged & FLAG_WMASK;
        IDX_ACTIVE_STACK: begin
          if (q.flags[FLAG_STACK_SEL]) begin
            d.irq_sp = merged;
          end else begin
            d.usr_sp = merged;
          end
        end
        default: d.bank[bk][full_idx] = merged;
      endcase
    end

    // An ALU update in the same cycle as a flag write wins for C, Z and S,
    // because the instruction's own result must be visible next.
    if (alu_upd.we) begin
      d.flags[FLAG_CARRY] = alu_upd.carry;
      d.flags[FLAG_ZERO] = (alu_upd.result == 32'h0000_0000);
      d.flags[FLAG_SIGN] = alu_upd.result[31];
    end

    // The active pointer follows the select flag as it will stand next.
    d.sp = d.flags[FLAG_STACK_SEL] ? d.irq_sp : d.usr_sp;

    unique case (ea_req.base)
      BASE_ADR0: base = q.bank[bk][IDX_ADDRESS_REG_ZERO[3:0]];
      BASE_ADR1: base = q.bank[bk][IDX_ADDRESS_REG_ONE[3:0]];
      BASE_ADR2: base = q.bank[bk][IDX_ADDRESS_REG_TWO[3:0]];
      BASE_ADR3: base = q.bank[bk][IDX_ADDRESS_REG_THREE[3:0]];
      BASE_STATIC: base = q.bank[bk][IDX_STATIC_BASE[3:0]];
      BASE_FRAME: base = q.bank[bk][IDX_FRAME_BASE[3:0]];
      BASE_VEC: base = q.vtb;
      default: base = 32'h0000_0000;
    endcase
    // Address sums wrap at 32 bits, as the core's address space does.
    d.ea = base + ea_req.offset;
    d.ea_valid = ea_req.valid;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign ea_addr = q.ea;
  assign ea_valid = q.ea_valid;
  assign sp_active = q.sp;
  assign next_instr_pointer = q.pc;
  assign cpu_status_flags = q.flags;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  zero_flag_a: assert property (
    alu_upd.we |=> cpu_status_flags[FLAG_ZERO] ==
      ($past(alu_upd.result) == 32'h0000_0000))
    else $error("zero flag does not match the result");

  sign_flag_a: assert property (
    alu_upd.we |=> cpu_status_flags[FLAG_SIGN] == $past(alu_upd.result[31]))
    else $error("sign flag does not match the result");

  carry_flag_a: assert property (
    alu_upd.we |=> cpu_status_flags[FLAG_CARRY] == $past(alu_upd.carry))
    else $error("carry flag does not follow the ALU");

  pc_advance_a: assert property (
    !(reg_wr && reg_addr == IDX_NEXT_INSTR_POINTER) |=>
      next_instr_pointer == $past(next_instr_pointer) + 32'($past(pc_step)))
    else $error("program counter did not advance by the step");

  user_stack_a: assert property (
    reg_wr && reg_addr == IDX_USER_STACK_POINTER &&
      !cpu_status_flags[FLAG_STACK_SEL] |=> sp_active == $past(reg_wdata))
    else $error("active stack is not the user pointer");

  half_read_a: assert property (
    (reg_wr && reg_addr == IDX_DATA_PAIR_ZERO) ##1
      (reg_rd && !reg_wr && reg_addr == IDX_PAIR_ZERO_UPPER_HALF) |=>
      reg_rdata == {16'h0000, $past(reg_wdata[31:16], 2)})
    else $error("upper half does not show the pair's upper bits");

  byte_read_a: assert property (
    (reg_wr && reg_addr == IDX_PAIR_ZERO_BYTE0) ##1
      (reg_rd && !reg_wr && reg_addr == IDX_PAIR_ZERO_BYTE0) |=>
      reg_rdata == {24'h000000, $past(reg_wdata[7:0], 2)})
    else $error("lowest byte register does not read back");

  lane_merge_a: assert property (
    (reg_wr && reg_addr == IDX_DATA_PAIR_ONE) ##1
      (reg_wr && reg_addr == IDX_PAIR_ONE_BYTE0) ##1
      (reg_rd && !reg_wr && reg_addr == IDX_DATA_PAIR_ONE) |=>
      reg_rdata[31:8] == $past(reg_wdata[31:8], 3))
    else $error("byte write disturbed other bytes of the pair");

  static_base_a: assert property (
    (reg_wr && reg_addr == IDX_STATIC_BASE && !alu_upd.we) ##1
      (ea_req.valid && ea_req.base == BASE_STATIC) |=>
      ea_valid && ea_addr == $past(reg_wdata, 2) + $past(ea_req.offset))
    else $error("static base address sum is wrong");

  frame_base_a: assert property (
    (reg_wr && reg_addr == IDX_FRAME_BASE) ##1
      (ea_req.valid && ea_req.base == BASE_FRAME) |=>
      ea_addr == $past(reg_wdata, 2) + $past(ea_req.offset))
    else $error("frame base address sum is wrong");

  addr_base_a: assert property (
    (reg_wr && reg_addr == IDX_ADDRESS_REG_ZERO) ##1
      (ea_req.valid && ea_req.base == BASE_ADR0) |=>
      ea_addr == $past(reg_wdata, 2) + $past(ea_req.offset))
    else $error("address register base sum is wrong");

  vector_base_a: assert property (
    (reg_wr && reg_addr == IDX_VECTOR_TABLE_BASE) ##1
      (ea_req.valid && ea_req.base == BASE_VEC) |=>
      ea_addr == $past(reg_wdata, 2) + $past(ea_req.offset))
    else $error("vector table address sum is wrong");

  bank_switch_c: cover property (
    reg_wr && reg_addr == IDX_CPU_STATUS_FLAGS && reg_wdata[FLAG_BANK]);

  irq_stack_c: cover property (
    cpu_status_flags[FLAG_STACK_SEL] ##1 reg_wr &&
      reg_addr == IDX_ACTIVE_STACK);

  byte_write_c: cover property (
    reg_wr && reg_addr == IDX_PAIR_ONE_BYTE3 ##1 reg_rd);

endmodule

/* File: hw/cfl_subreg_map.sv */
// Maps a register index onto its whole register, lane shift and lane mask.
`timescale 1ns/100ps
module cfl_subreg_map
  import cfl_pkg::*;
(
  input wire logic [4:0] addr,
  output logic [3:0] full_idx,
  output logic [4:0] shift,
  output logic [31:0] mask
);

  always_comb begin
    full_idx = addr[3:0];
    shift = 5'h00;
    mask = 32'hFFFF_FFFF;
    if (addr >= IDX_BYTE_BASE) begin
      full_idx = {3'h0, addr[2]};
      shift = {addr[1:0], 3'h0};
      mask = 32'h0000_00FF << shift;
    end else if (addr >= IDX_HALF_BASE) begin
      full_idx = {2'h0, addr[2:1]};
      shift = {addr[0], 4'h0};
      mask = 32'h0000_FFFF << shift;
    end
  end

endmodule

/* File: test/cfl_core_model.sv */
// Decoder and ALU side model: flag updates, address requests, pc step.
`timescale 1ns/100ps
module cfl_core_model
  import cfl_pkg::*;
#(
  parameter int unsigned PC_STEP_W = 4,
  parameter int unsigned STEP = 4
)(
  input wire logic mclk,
  output cfl_alu_upd_t alu_upd,
  output logic [PC_STEP_W-1:0] pc_step,
  output cfl_ea_req_t ea_req
);
  initial begin
    alu_upd = '0;
    ea_req = '0;
    pc_step = PC_STEP_W'(STEP);
  end

  // Released fields show the inverse so a stale value is never mistaken.
  task automatic alu_op(input logic [31:0] res, input logic cy);
    @(posedge mclk);
    alu_upd <= '{we: 1'b1, result: res, carry: cy};
    @(posedge mclk);
    alu_upd <= '{we: 1'b0, result: ~res, carry: ~cy};
  endtask

  task automatic ea_op(input logic [2:0] b, input logic [31:0] off);
    @(posedge mclk);
    ea_req <= '{valid: 1'b1, base: cfl_base_t'(b), offset: off};
    @(posedge mclk);
    ea_req <= '{valid: 1'b0, base: cfl_base_t'(~b), offset: ~off};
  endtask
endmodule

/* File: test/test_cpu_register_file_flags.sv */
// Self-checking bench of the CPU register file.
`timescale 1ns/100ps
module test_cpu_register_file_flags;
  import cfl_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, ea_addr, sp_active, pc_q, flags_seen;
  logic ea_valid;
  cfl_alu_upd_t alu_upd;
  logic [3:0] pc_step;
  cfl_ea_req_t ea_req;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  typedef struct {logic [4:0] wa; logic [31:0] wd; logic [4:0] ra;
    logic [31:0] exp;} cfl_row_t;
  cfl_row_t rows[8];

  always #2 mclk = ~mclk;

  cfl_regfile #(.PC_STEP_W(4)) dut (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_upd(alu_upd),
    .pc_step(pc_step), .ea_req(ea_req), .ea_addr(ea_addr),
    .ea_valid(ea_valid), .sp_active(sp_active),
    .next_instr_pointer(pc_q), .cpu_status_flags(flags_seen));

  cfl_core_model #(.PC_STEP_W(4), .STEP(4)) core (.mclk(mclk),
    .alu_upd(alu_upd), .pc_step(pc_step), .ea_req(ea_req));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Data are sampled just after the taking edge, in the only cycle they stand.
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    logic [31:0] d;
    logic [2:0] bs[5];
    logic [31:0] be[5];
    rows[0] = '{5'h00, 32'h1234_5678, 5'h00, 32'h1234_5678};
    rows[1] = '{5'h11, 32'h0000_ABCD, 5'h00, 32'hABCD_5678};
    rows[2] = '{5'h1B, 32'h0000_00EF, 5'h00, 32'hEFCD_5678};
    rows[3] = '{5'h01, 32'hAABB_CCDD, 5'h1D, 32'h0000_00CC};
    rows[4] = '{5'h17, 32'h0000_1234, 5'h03, 32'h1234_0000};
    rows[5] = '{5'h0B, 32'h0000_1000, 5'h0B, 32'h0000_1000};
    rows[6] = '{5'h0C, 32'h0000_2000, 5'h0F, 32'h0000_2000};
    rows[7] = '{5'h0E, 32'h0000_0001, 5'h0E, 32'h0000_0001};
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    #1 check("flags after reset", flags_seen, RST_FLAGS);
    check("ea_valid after reset", {31'h0, ea_valid}, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, d);
      check("row read", d, rows[i].exp);
    end
    // A bank switch must hide the first bank's static base.
    wr(IDX_STATIC_BASE, 32'h0000_0111);
    wr(IDX_CPU_STATUS_FLAGS, 32'h0000_0010);
    @(posedge mclk);
    rd(IDX_STATIC_BASE, d);
    check("second bank base", d, 32'h0);
    wr(IDX_STATIC_BASE, 32'h0000_0222);
    wr(IDX_CPU_STATUS_FLAGS, 32'h0);
    @(posedge mclk);
    rd(IDX_STATIC_BASE, d);
    check("first bank base", d, 32'h0000_0111);
    wr(IDX_ADDRESS_REG_TWO, 32'h0000_4000);
    wr(IDX_FRAME_BASE, 32'h0000_5000);
    bs = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    be = '{32'h4010, 32'h0121, 32'h5010, 32'h1010, 32'h0010};
    foreach (bs[i]) begin
      core.ea_op(bs[i], 32'h0000_0010);
      #1 check("ea_valid", {31'h0, ea_valid}, 32'h1);
      check("ea_addr", ea_addr, be[i]);
    end
    wr(IDX_IRQ_STACK_POINTER, 32'h0000_3000);
    wr(IDX_CPU_STATUS_FLAGS, 32'h0000_0080);
    @(posedge mclk);
    #1 check("sp_active", sp_active, 32'h0000_3000);
    rd(IDX_ACTIVE_STACK, d);
    check("active sp read", d, 32'h0000_3000);
    core.alu_op(32'h0, 1'b1);
    #1 check("flags zero", flags_seen & 32'hD, 32'h5);
    core.alu_op(32'h8000_0000, 1'b0);
    #1 check("flags sign", flags_seen & 32'hD, 32'h8);
    core.alu_op(32'h0000_0001, 1'b0);
    #1 check("flags clear", flags_seen & 32'hD, 32'h0);
    wr(IDX_NEXT_INSTR_POINTER, 32'h0000_0100);
    #1 check("pc written", pc_q, 32'h0000_0100);
    @(posedge mclk);
    #1 check("pc step", pc_q, 32'h0000_0104);
    close_out();
  end
endmodule
